// ---- mbew_pkg.sv ----
// Constants and carrier types for the host-bus emulation write master.
// Assumes a single 200 MHz system clock; the bus clock is divided from it.
package mbew_pkg;

    // System clock
    localparam real CLK_PERIOD_NS = 5.0;

    // Bus clock half period, rounded up so the bus never runs too fast
    localparam real BUS_HALF_NS   = 41.6;
    localparam int  BUS_HALF_CLKS = int'($ceil(BUS_HALF_NS / CLK_PERIOD_NS));

    // Phase lengths in bus clocks
    localparam int HI_ADDR_CLKS    = 1;
    localparam int ADDR_SETUP_CLKS = 1;
    localparam int ALE_NOM_CLKS    = 1;
    localparam int ALE_EXT_CLKS    = 2;
    localparam int DATA_SETUP_CLKS = 1;
    localparam int WR_NOM_CLKS     = 1;
    localparam int WR_EXT_CLKS     = 6;
    localparam int RELEASE_CLKS    = 1;

    localparam int CNT_W = 3;

    // Reset values
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HI,
        ST_ADDR,
        ST_ALE,
        ST_CS,
        ST_WR,
        ST_REL
    } mbew_state_t;

    typedef struct packed {
        logic       ext;
        logic [7:0] hi_addr;
        logic [7:0] lo_addr;
        logic [7:0] data;
    } mbew_cmd_t;

endpackage

// ---- mbew_write_master.sv ----
// Bus-master write sequencer for an 8048/8051-style multiplexed host bus.
// Assumes commands come from logic on clk_in; wait_ready_in is an
// asynchronous pin and is synchronised before use.
//
// Operation
// - When the peripheral holds ready low, the latch strobe and write strobe phases take their fixed extended lengths.
// - The bus clock pin carries the very clock that steps the bus cycle.
// - The upper address byte sits on eight dedicated output lines.
// - Chip select is one low pulse covering the data setup and the whole write strobe.
// - The address latch strobe is a positive pulse whose falling edge latches the low address.
// - Write data is stable before the write strobe falls and after it rises.
// - Only an extended write first places a new upper address byte; a plain write leaves it.
// - The low address is driven for one bus clock before the latch strobe rises.
// - The latch strobe is high one bus clock, or two when ready is low.
// - Chip select falls at the same step as the latch strobe falls.
// - Data is driven at the same step as chip select falls, with one bus clock of setup before the write strobe.
// - The write strobe is low one bus clock, or six when ready is low.
// - Chip select rises half a bus clock after the write strobe rises.
// - Write data stays driven until chip select has been released.
// - The low bus carries the low address first and the data byte afterwards.
// - Both extended and plain writes are supported.
`timescale 1ns/1ps

module mbew_write_master
    import mbew_pkg::*;
(
    input  wire logic      clk_in,
    input  wire logic      reset_in,
    input  wire logic      req_valid_in,
    input  wire mbew_cmd_t req_cmd_in,
    output logic           req_ready_out,
    output logic           busy_out,
    input  wire logic      wait_ready_in,
    output logic           bus_clock_out,
    output logic [7:0]     upper_addr_out,
    output logic [7:0]     mux_bus_out,
    output logic           mux_bus_oe_out,
    output logic           ale_out,
    output logic           cs_n_out,
    output logic           rd_n_out,
    output logic           wr_n_out
);

    localparam logic [7:0]       DIV_LAST = 8'(BUS_HALF_CLKS - 1);
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    // Bus clock divider
    logic [7:0] div_q;
    logic [7:0] div_d;
    logic       bclk_q;
    logic       bclk_d;

    // Ready synchroniser
    logic rdy_meta_q;
    logic rdy_sync_q;

    // Sequencer
    mbew_state_t      state_q;
    mbew_state_t      state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             ext_q;
    logic [7:0]       lo_q;
    logic [7:0]       dat_q;
    logic [7:0]       upper_q;
    logic [7:0]       upper_d;
    logic [7:0]       mux_q;
    logic [7:0]       mux_d;
    logic             cs_n_q;
    logic             cs_n_d;

    // Decode
    wire              div_wrap  = (div_q == DIV_LAST);
    wire              rise_tick = div_wrap && !bclk_q;
    wire              fall_tick = div_wrap && bclk_q;
    wire              take      = req_valid_in && req_ready_out;
    wire              rdy_low   = !rdy_sync_q;
    wire [CNT_W-1:0]  limit;
    wire              phase_end = rise_tick && (cnt_q >= limit - CNT_ONE);

    assign limit =
        (state_q == ST_HI)   ? CNT_W'(HI_ADDR_CLKS) :
        (state_q == ST_ADDR) ? CNT_W'(ADDR_SETUP_CLKS) :
        (state_q == ST_ALE)  ? (rdy_low ? CNT_W'(ALE_EXT_CLKS) : CNT_W'(ALE_NOM_CLKS)) :
        (state_q == ST_CS)   ? CNT_W'(DATA_SETUP_CLKS) :
        (state_q == ST_WR)   ? (rdy_low ? CNT_W'(WR_EXT_CLKS) : CNT_W'(WR_NOM_CLKS)) :
        CNT_W'(RELEASE_CLKS);

    assign div_d  = div_wrap ? 8'h00 : div_q + 8'h01;
    assign bclk_d = div_wrap ? !bclk_q : bclk_q;

    assign req_ready_out  = (state_q == ST_IDLE) && rise_tick;
    assign busy_out       = (state_q != ST_IDLE);
    assign bus_clock_out  = bclk_q;
    assign upper_addr_out = upper_q;
    assign mux_bus_out    = mux_q;
    assign mux_bus_oe_out = (state_q != ST_IDLE) && (state_q != ST_HI);
    assign ale_out        = (state_q == ST_ALE);
    assign cs_n_out       = cs_n_q;
    assign rd_n_out       = 1'h1;
    assign wr_n_out       = (state_q != ST_WR);

    // Next state: every phase boundary falls on a bus clock rising edge
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        upper_d = upper_q;
        mux_d   = mux_q;
        cs_n_d  = cs_n_q;
        if (rise_tick) begin
            cnt_d = cnt_q + CNT_ONE;
        end
        unique case (state_q)
            ST_IDLE: begin
                cnt_d = '0;
                if (take) begin
                    if (req_cmd_in.ext) begin
                        state_d = ST_HI;
                        upper_d = req_cmd_in.hi_addr;
                    end else begin
                        state_d = ST_ADDR;
                        mux_d   = req_cmd_in.lo_addr;
                    end
                end
            end
            ST_HI: begin
                if (phase_end) begin
                    state_d = ST_ADDR;
                    cnt_d   = '0;
                    mux_d   = lo_q;
                end
            end
            ST_ADDR: begin
                if (phase_end) begin
                    state_d = ST_ALE;
                    cnt_d   = '0;
                end
            end
            ST_ALE: begin
                if (phase_end) begin
                    state_d = ST_CS;
                    cnt_d   = '0;
                    cs_n_d  = 1'h0;
                    mux_d   = dat_q;
                end
            end
            ST_CS: begin
                if (phase_end) begin
                    state_d = ST_WR;
                    cnt_d   = '0;
                end
            end
            ST_WR: begin
                if (phase_end) begin
                    state_d = ST_REL;
                    cnt_d   = '0;
                end
            end
            ST_REL: begin
                // Half a bus clock after the strobe rises, select goes away
                if (fall_tick) begin
                    cs_n_d = 1'h1;
                end
                if (phase_end) begin
                    state_d = ST_IDLE;
                    cnt_d   = '0;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            div_q  <= 8'h00;
            bclk_q <= 1'h0;
        end else begin
            div_q  <= div_d;
            bclk_q <= bclk_d;
        end
    end

    // Ready is a pin; only the second stage is read
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rdy_meta_q <= 1'h1;
            rdy_sync_q <= 1'h1;
        end else begin
            rdy_meta_q <= wait_ready_in;
            rdy_sync_q <= rdy_meta_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ext_q <= 1'b0;
            lo_q  <= ADDR_RESET;
            dat_q <= DATA_RESET;
        end else if (take) begin
            ext_q <= req_cmd_in.ext;
            lo_q  <= req_cmd_in.lo_addr;
            dat_q <= req_cmd_in.data;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
            upper_q <= ADDR_RESET;
            mux_q   <= DATA_RESET;
            cs_n_q  <= 1'h1;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            upper_q <= upper_d;
            mux_q   <= mux_d;
            cs_n_q  <= cs_n_d;
        end
    end

    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    // Helper: write strobe low time in system clocks
    logic [7:0] wr_low_cnt_q;
    always_ff @(posedge clk_in) begin
        if (reset_in || wr_n_out) begin
            wr_low_cnt_q <= 8'h00;
        end else begin
            wr_low_cnt_q <= wr_low_cnt_q + 8'h01;
        end
    end
    localparam logic [7:0] WR_MAX_CLKS = 8'(WR_EXT_CLKS * 2 * BUS_HALF_CLKS);
    localparam int         HALF_M1     = BUS_HALF_CLKS - 1;

    // Helper: run lengths of the bus clock high phase and of the latch strobe,
    // counted because a repetition of that many cycles is too costly to unroll
    logic [7:0] bclk_hi_cnt_q;
    logic [7:0] ale_hi_cnt_q;
    always_ff @(posedge clk_in) begin
        if (reset_in || !bus_clock_out) begin
            bclk_hi_cnt_q <= 8'h00;
        end else begin
            bclk_hi_cnt_q <= bclk_hi_cnt_q + 8'h01;
        end
    end
    always_ff @(posedge clk_in) begin
        if (reset_in || !ale_out) begin
            ale_hi_cnt_q <= 8'h00;
        end else begin
            ale_hi_cnt_q <= ale_hi_cnt_q + 8'h01;
        end
    end
    localparam logic [7:0] HALF_CLKS   = 8'(BUS_HALF_CLKS);
    localparam logic [7:0] ALE_NOM_SYS = 8'(ALE_NOM_CLKS * 2 * BUS_HALF_CLKS);
    localparam logic [7:0] ALE_EXT_SYS = 8'(ALE_EXT_CLKS * 2 * BUS_HALF_CLKS);

    sequence s_wr_end;
        $rose(wr_n_out);
    endsequence

    sequence s_cs_release;
        !cs_n_out ##HALF_M1 1'h1 ##1 cs_n_out;
    endsequence

    property p_bus_clock;
        $fell(bus_clock_out) |-> (bclk_hi_cnt_q == HALF_CLKS);
    endproperty
    a_bus_clock: assert property (p_bus_clock) else $error("bus clock high time wrong");

    property p_cs_covers_wr;
        !wr_n_out |-> !cs_n_out && !ale_out;
    endproperty
    a_cs_covers_wr: assert property (p_cs_covers_wr) else $error("write strobe outside select");

    property p_ale_cs;
        $fell(ale_out) |-> $fell(cs_n_out);
    endproperty
    a_ale_cs: assert property (p_ale_cs) else $error("select did not fall with latch strobe");

    property p_ale_width;
        $fell(ale_out) |-> (ale_hi_cnt_q == ALE_NOM_SYS) || (ale_hi_cnt_q == ALE_EXT_SYS);
    endproperty
    a_ale_width: assert property (p_ale_width) else $error("latch strobe width wrong");

    property p_addr_setup;
        $rose(ale_out) |-> $past(mux_bus_oe_out, 2) && $stable(mux_bus_out);
    endproperty
    a_addr_setup: assert property (p_addr_setup) else $error("address not set up before latch");

    property p_wr_data;
        $fell(wr_n_out) |-> mux_bus_oe_out && $stable(mux_bus_out) && !$past(cs_n_out, 2);
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("data not set up before write");

    property p_wr_max;
        wr_low_cnt_q <= WR_MAX_CLKS;
    endproperty
    a_wr_max: assert property (p_wr_max) else $error("write strobe low too long");

    property p_cs_half;
        s_wr_end |-> s_cs_release;
    endproperty
    a_cs_half: assert property (p_cs_half) else $error("select not released half clock after write");

    property p_data_hold;
        (!cs_n_out && !$fell(cs_n_out)) |-> $stable(mux_bus_out) && mux_bus_oe_out;
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data changed while selected");

    property p_plain_upper;
        (state_q == ST_ADDR && !ext_q) |-> $stable(upper_addr_out);
    endproperty
    a_plain_upper: assert property (p_plain_upper) else $error("plain write moved upper address");

    property p_idle;
        (state_q == ST_IDLE) |-> cs_n_out && wr_n_out && rd_n_out && !ale_out;
    endproperty
    a_idle: assert property (p_idle) else $error("strobes active while idle");

endmodule

// ---- mbew_periph_model.sv ----
// Peripheral model on the far side of the write master.
// Latches address and data the way a multiplexed-bus chip does; it samples on the shared clock.
`timescale 1ns/1ps

module mbew_periph_model (
    input  wire logic        clk_in,
    input  wire logic        stall_in,
    input  wire logic [7:0]  upper_in,
    input  wire logic [7:0]  mux_in,
    input  wire logic        ale_in,
    input  wire logic        wr_n_in,
    output logic             wait_ready_out,
    output logic [15:0]      addr_out,
    output logic [7:0]       data_out,
    output logic [7:0]       wr_cnt_out
);
    logic [7:0] lo_q;
    logic       wr_n_q;

    // Line is pulled up unless a scenario asks for a stall
    assign wait_ready_out = !stall_in;

    initial begin
        wr_cnt_out = 8'h00;
        wr_n_q = 1'h1;
    end

    // Sampling on the clock avoids a race with the bus turning to data at the latch edge
    always @(posedge clk_in) begin
        if (ale_in) begin
            lo_q <= mux_in;
        end
        if (!wr_n_in) begin
            data_out <= mux_in;
            addr_out <= {upper_in, lo_q};
        end
        if (!wr_n_q && wr_n_in) begin
            wr_cnt_out <= wr_cnt_out + 8'h01;
        end
        wr_n_q <= wr_n_in;
    end
endmodule

// ---- mbew_write_master_bench.sv ----
// Self-checking bench for the host-bus write master.
// Inputs change on the falling clock edge; the peripheral model answers on the bus.
`timescale 1ns/1ps

module mbew_write_master_bench;
    import mbew_pkg::*;

    logic        clk_in = 1'h0;
    logic        reset_in = 1'h1;
    logic        req_valid_in = 1'h0;
    logic        stall = 1'h0;
    mbew_cmd_t   req_cmd_in = '0;
    logic        req_ready_out, busy_out, wait_ready_in, bus_clock_out;
    logic        mux_bus_oe_out, ale_out, cs_n_out, rd_n_out, wr_n_out;
    logic [7:0]  upper_addr_out, mux_bus_out, m_data, m_cnt;
    logic [15:0] m_addr;
    int          error_cnt = 0;
    int          n_tests = 0;
    int          cyc = 0;

    mbew_write_master u_mbew_write_master (
        .clk_in, .reset_in, .req_valid_in, .req_cmd_in, .req_ready_out, .busy_out,
        .wait_ready_in, .bus_clock_out, .upper_addr_out, .mux_bus_out, .mux_bus_oe_out,
        .ale_out, .cs_n_out, .rd_n_out, .wr_n_out
    );

    mbew_periph_model u_mbew_periph_model (
        .clk_in, .stall_in(stall), .upper_in(upper_addr_out), .mux_in(mux_bus_out),
        .ale_in(ale_out), .wr_n_in(wr_n_out), .wait_ready_out(wait_ready_in),
        .addr_out(m_addr), .data_out(m_data), .wr_cnt_out(m_cnt)
    );

    always #2.5 clk_in = !clk_in;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Worst case is about 220 cycles a write, so this leaves ample margin
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            error_cnt++;
            wrap_up();
        end
    end

    // Called at a falling edge with the master idle; counts each phase in clock samples
    task automatic do_write(input logic ext, input logic [7:0] hi, lo, dat, input logic stl);
        int         nb = 0, na = 0, nw = 0, nc = 0, ng = 0, ns = 0, nh = 0, nd = 0, bad = 0, g = 0;
        logic [7:0] up0;
        logic [7:0] cnt0;
        logic       bclk = 1'h0;
        up0 = upper_addr_out;
        cnt0 = m_cnt;
        stall = stl;
        req_cmd_in = '{ext, hi, lo, dat};
        req_valid_in = 1'h1;
        while (req_ready_out !== 1'h1 && g < 100) begin
            @(negedge clk_in);
            g++;
        end
        @(negedge clk_in);
        req_valid_in = 1'h0;
        while (busy_out === 1'h1 && nb < 500) begin
            nb++;
            if (ale_out === 1'h1) begin
                na++;
                if (na == 1) begin
                    bclk = bus_clock_out;
                end
                if (mux_bus_out !== lo) begin
                    bad++;
                end
            end
            if (mux_bus_oe_out === 1'h0 && na == 0) begin
                nh++;
            end
            if (mux_bus_oe_out === 1'h1 && ale_out === 1'h0 && cs_n_out === 1'h1 && na == 0) begin
                ns++;
            end
            if (cs_n_out === 1'h0) begin
                nc++;
                if (mux_bus_out !== dat || mux_bus_oe_out !== 1'h1) begin
                    bad++;
                end
                if (wr_n_out === 1'h1 && nw == 0) begin
                    nd++;
                end
                if (wr_n_out === 1'h1 && nw > 0) begin
                    ng++;
                end
            end
            if (wr_n_out === 1'h0) begin
                nw++;
            end
            if (rd_n_out !== 1'h1) begin
                bad++;
            end
            @(negedge clk_in);
        end
        check(16'(na), stl ? 16'h0024 : 16'h0012);
        check(16'(nw), stl ? 16'h006C : 16'h0012);
        check(16'(nc), stl ? 16'h0087 : 16'h002D);
        check(16'(nd), 16'h0012);
        check(16'(ng), 16'h0009);
        check(16'(ns), 16'h0012);
        check(16'(nh), ext ? 16'h0012 : 16'h0000);
        check(16'(nb), 16'(90 + 18 * ext + 108 * stl));
        check(16'(bad), 16'h0000);
        check({15'h0000, bclk}, 16'h0001);
        check({8'h00, upper_addr_out}, {8'h00, ext ? hi : up0});
        check(m_addr, {ext ? hi : up0, lo});
        check({8'h00, m_data}, {8'h00, dat});
        check({8'h00, m_cnt}, {8'h00, cnt0 + 8'h01});
        check({12'h000, cs_n_out, wr_n_out, rd_n_out, ale_out}, 16'h000E);
    endtask

    initial begin
        repeat (3) @(negedge clk_in);
        reset_in = 1'h0;
        check({12'h000, cs_n_out, wr_n_out, rd_n_out, ale_out}, 16'h000E);
        // Back-to-back writes with boundary bytes, plain and extended, with and without stall
        do_write(1'h0, 8'hA5, 8'h00, 8'hFF, 1'h0);
        do_write(1'h1, 8'h3C, 8'hC3, 8'h5A, 1'h0);
        do_write(1'h0, 8'hFF, 8'h81, 8'h7E, 1'h1);
        do_write(1'h1, 8'hFF, 8'hFF, 8'h00, 1'h1);
        wrap_up();
    end
endmodule
